/* core/linear_array_frame_sequencer.v */
// frame sequencer: integrate, convert, frame-ready and read-out stream
// Notes on behaviour
// - Every 8-bit read-out except all-low zebra puts the converted temperature in byte 6.
// - Reset puts all sequencing logic in a defined state first.
// - Integration starts only on a start-integration command, or on chip select after a zebra command.
// - After integration a conversion of at least the delay precedes ready.
// - Zebra test commands follow the same sequence as normal frames.
// - Zebra integration starts on chip-select rising edge, fixed time.
// - All-low zebra with 8-bit read-out gives a dark-level temp byte.
`include "frame_seq_consts.vh"
`default_nettype none
module linear_array_frame_sequencer #(
    parameter FRAME_BYTES = 8'h10,
    parameter CONV_CYCLES = `FRAME_AVAIL_DELAY_US * `CLK_MHZ,
    parameter ZEB_CYCLES  = `ZEBRA_INTEG_US * `CLK_MHZ
) (
    // clock and reset
    input  wire       ref_clk,
    input  wire       arst_n,
    // decoded command strobe
    input  wire       cmd_valid,
    input  wire [2:0] cmd_code,
    input  wire [15:0] integ_cycles,
    input  wire [1:0] resolution,
    input  wire       chip_select,
    // analog side
    input  wire [7:0] pixel_data,
    input  wire [7:0] temp_adc,
    // read-out stream
    input  wire       rd_req,
    output reg        out_valid_ff,
    output reg  [7:0] out_data_ff,
    input  wire       out_ready,
    // status
    output reg        frame_available_flag_ff,
    output reg        initialised_ff,
    output reg        cmd_error_ff
);
    localparam ST_IDLE  = 5'h01;
    localparam ST_ZWAIT = 5'h02;
    localparam ST_INTEG = 5'h04;
    localparam ST_CONV  = 5'h08;
    localparam ST_READ  = 5'h10;

    reg [4:0]  state_ff;
    reg [4:0]  nxt_state;
    reg [23:0] cnt_ff;
    reg [23:0] nxt_cnt;
    reg [7:0]  idx_ff;
    reg [1:0]  res_ff;
    reg        zero_ff;
    reg        cs_d_ff;
    reg [7:0]  buf_ff [0:1];
    reg        wp_ff;
    reg        rp_ff;
    reg [1:0]  cnt_buf_ff;
    wire       is_zebra;
    wire       buf_ready;
    wire       push;
    wire       pop;
    reg [7:0]  src_byte;
    // phase lengths are cut to the counter width on purpose
    wire [31:0] conv_full;
    wire [31:0] zeb_full;

    // chip reset is honoured in every phase, so it is decoded once
    function is_chip_reset;
        input       valid;
        input [2:0] code;
        begin
            is_chip_reset = valid && (code == `CMD_CHIP_RESET);
        end
    endfunction

    // shared by the integration and conversion countdowns
    function [23:0] dec_cnt;
        input [23:0] value;
        begin
            dec_cnt = value - 24'h000001;
        end
    endfunction

    assign is_zebra = (cmd_code == `CMD_ZEBRA_ALL_LOW) ||
                      (cmd_code == `CMD_ZEBRA_ODD_HIGH) ||
                      (cmd_code == `CMD_ZEBRA_EVEN_HIGH) ||
                      (cmd_code == `CMD_ZEBRA_ALL_HIGH);
    assign buf_ready = (cnt_buf_ff != 2'h2);
    assign push = (state_ff == ST_READ) && buf_ready;
    assign pop  = out_valid_ff && out_ready;
    assign conv_full = CONV_CYCLES;
    assign zeb_full  = ZEB_CYCLES;

    always @* begin
        if ((idx_ff == `TEMP_BYTE_POS) && (res_ff == `RES_8BIT)) begin
            src_byte = zero_ff ? `DARK_LEVEL : temp_adc;
        end else begin
            src_byte = pixel_data;
        end
    end

    always @* begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (cmd_valid && initialised_ff &&
                    cmd_code == `CMD_START_INTEG) begin
                    nxt_state = ST_INTEG;
                    // the zero count is a cycle too: integ_cycles + 1 long
                    nxt_cnt   = {8'h00, integ_cycles};
                end else if (cmd_valid && initialised_ff && is_zebra) begin
                    nxt_state = ST_ZWAIT;
                end
            end
            ST_ZWAIT: begin
                // edge, not level: a select left high starts nothing
                if (chip_select && !cs_d_ff) begin
                    nxt_state = ST_INTEG;
                    nxt_cnt   = zeb_full[23:0];
                end
            end
            ST_INTEG: begin
                if (cnt_ff == 24'h000000) begin
                    nxt_state = ST_CONV;
                    nxt_cnt   = conv_full[23:0];
                end else begin
                    nxt_cnt = dec_cnt(cnt_ff);
                end
            end
            ST_CONV: begin
                if (cnt_ff <= 24'h000001) begin
                    nxt_state = ST_READ;
                end else begin
                    nxt_cnt = dec_cnt(cnt_ff);
                end
            end
            ST_READ: begin
                if (push && idx_ff == FRAME_BYTES - 8'h01) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (is_chip_reset(cmd_valid, cmd_code)) begin
            nxt_state = ST_IDLE;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 24'h000000;
            idx_ff <= 8'h00;
            res_ff <= `RES_8BIT;
            zero_ff <= 1'b0;
            cs_d_ff <= 1'b0;
            wp_ff <= 1'b0;
            rp_ff <= 1'b0;
            cnt_buf_ff <= 2'h0;
            out_valid_ff <= 1'b0;
            out_data_ff <= 8'h00;
            frame_available_flag_ff <= 1'b0;
            initialised_ff <= 1'b0;
            cmd_error_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            cs_d_ff <= chip_select;
            if (is_chip_reset(cmd_valid, cmd_code)) begin
                initialised_ff <= 1'b1;
                cmd_error_ff <= 1'b0;
            end else if (cmd_valid && (!initialised_ff ||
                         state_ff != ST_IDLE)) begin
                cmd_error_ff <= 1'b1;
            end
            if (cmd_valid && state_ff == ST_IDLE && is_zebra) begin
                zero_ff <= (cmd_code == `CMD_ZEBRA_ALL_LOW);
            end else if (cmd_valid && cmd_code == `CMD_START_INTEG) begin
                zero_ff <= 1'b0;
            end
            // ready rises when conversion is done, drops on new work
            if (nxt_state == ST_READ && state_ff == ST_CONV) begin
                frame_available_flag_ff <= 1'b1;
                res_ff <= resolution;
                idx_ff <= 8'h00;
            end else if (nxt_state == ST_INTEG || nxt_state == ST_ZWAIT ||
                         is_chip_reset(cmd_valid, cmd_code)) begin
                frame_available_flag_ff <= 1'b0;
            end
            if (push && !is_chip_reset(cmd_valid, cmd_code)) begin
                buf_ff[wp_ff] <= src_byte;
                wp_ff <= ~wp_ff;
                idx_ff <= idx_ff + 8'h01;
            end
            // two-entry buffer: stall by receiver never drops a byte
            if (pop) begin
                rp_ff <= ~rp_ff;
            end
            case ({push, pop})
                2'b10: cnt_buf_ff <= cnt_buf_ff + 2'h1;
                2'b01: cnt_buf_ff <= cnt_buf_ff - 2'h1;
                default: cnt_buf_ff <= cnt_buf_ff;
            endcase
            // pop of the last entry idles a cycle: short path, small rate cost
            if (pop || !out_valid_ff) begin
                if (cnt_buf_ff - (pop ? 2'h1 : 2'h0) != 2'h0) begin
                    out_valid_ff <= 1'b1;
                    out_data_ff <= buf_ff[pop ? ~rp_ff : rp_ff];
                end else begin
                    out_valid_ff <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* core/frame_seq_consts.vh */
// constants for the linear array frame sequencer
`ifndef FRAME_SEQ_CONSTS_VH
`define FRAME_SEQ_CONSTS_VH
// command codes presented on cmd_code (decoded upstream)
`define CMD_CHIP_RESET      3'h1
`define CMD_START_INTEG     3'h2
`define CMD_WRITE_THRESHOLD 3'h3
`define CMD_ZEBRA_ALL_LOW   3'h4
`define CMD_ZEBRA_ODD_HIGH  3'h5
`define CMD_ZEBRA_EVEN_HIGH 3'h6
`define CMD_ZEBRA_ALL_HIGH  3'h7
// timing, clock 100 MHz
`define CLK_MHZ             100
`define FRAME_AVAIL_DELAY_US 20
`define ZEBRA_INTEG_US      10
// frame layout
`define TEMP_BYTE_POS       8'h06
`define RES_8BIT            2'h0
`define DARK_LEVEL          8'h10
`endif

/* tb/seq_assertions.sv */
// port assertions for the frame sequencer
`default_nettype none
`include "frame_seq_consts.vh"
module seq_assertions #(parameter CONV_CYCLES = 4) (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       arst_n,
    // commands and analog
    input wire logic       cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [1:0] resolution,
    input wire logic [7:0] temp_adc,
    // stream and status
    input wire logic       out_valid_ff,
    input wire logic [7:0] out_data_ff,
    input wire logic       out_ready,
    input wire logic       frame_available_flag_ff,
    input wire logic       initialised_ff,
    input wire logic       cmd_error_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] idx_ff;
    logic [7:0] low_ff;
    logic       zlow_ff;
    wire        fl = frame_available_flag_ff;
    wire        cr = cmd_valid && cmd_code == `CMD_CHIP_RESET;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            idx_ff <= 8'h00;
            low_ff <= 8'h00;
            zlow_ff <= 1'h0;
        end else begin
            idx_ff <= !fl ? 8'h00 : idx_ff + 8'(out_valid_ff && out_ready);
            low_ff <= fl ? 8'h00 : low_ff + 8'(low_ff != 8'hff);
            if (cmd_valid && cmd_code != `CMD_WRITE_THRESHOLD)
                zlow_ff <= cmd_code == `CMD_ZEBRA_ALL_LOW;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    a_chip_reset_init: assert property (cr |=> initialised_ff
        && !cmd_error_ff && !fl) else $error("chip reset not applied");
    a_refuse_uninit: assert property (cmd_valid && !initialised_ff
        && cmd_code == `CMD_START_INTEG |=> cmd_error_ff && !fl)
        else $error("start accepted before init");
    a_flag_low_uninit: assert property (!initialised_ff |-> !fl)
        else $error("flag high before init");
    a_conv_delay: assert property ($rose(fl) |-> low_ff > CONV_CYCLES)
        else $error("flag rose too early");
    a_stream_gated: assert property (out_valid_ff |-> fl)
        else $error("byte before frame ready");
    a_stall_holds: assert property (out_valid_ff && !out_ready |=>
        out_valid_ff && $stable(out_data_ff)) else $error("stall lost");
    a_temp_byte: assert property (out_valid_ff &&
        idx_ff == `TEMP_BYTE_POS && resolution == `RES_8BIT |->
        out_data_ff == (zlow_ff ? `DARK_LEVEL : temp_adc))
        else $error("byte 6 wrong");
    a_error_sticky: assert property (cmd_error_ff && !cr |=> cmd_error_ff)
        else $error("error flag dropped");
    a_flag_stands: assert property (fl && !cmd_valid |=> fl)
        else $error("flag dropped without command");
    c_ready: cover property ($rose(fl));
    c_stall: cover property (out_valid_ff && !out_ready);
    c_dark: cover property (zlow_ff && idx_ff == `TEMP_BYTE_POS && out_valid_ff);
endmodule
bind linear_array_frame_sequencer seq_assertions #(.CONV_CYCLES(CONV_CYCLES))
    seq_assertions_inst (.ref_clk, .arst_n, .cmd_valid, .cmd_code, .resolution,
    .temp_adc, .out_valid_ff, .out_data_ff, .out_ready,
    .frame_available_flag_ff, .initialised_ff, .cmd_error_ff);
`default_nettype wire

/* tb/host_rx_model.sv */
// host side receiver: reads only once frame ready, stalls at random
`default_nettype none
module host_rx_model (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // status and handshake
    input  wire logic frame_available_flag_ff,
    output wire logic out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] lfsr_ff;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) lfsr_ff <= 4'h9;
        else lfsr_ff <= {lfsr_ff[2:0], lfsr_ff[3] ^ lfsr_ff[2]};
    end
    // flag serves as the host interrupt; stalls fill the two-entry buffer
    assign out_ready = frame_available_flag_ff && lfsr_ff[1];
endmodule
`default_nettype wire

/* tb/test_linear_array_frame_sequencer.sv */
// self-checking bench for the frame sequencer
`default_nettype none
`include "frame_seq_consts.vh"
module test_linear_array_frame_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'h0, arst_n = 1'h0, cmd_valid = 1'h0;
    logic        chip_select = 1'h0, out_valid_ff, out_ready, fl, ini, err;
    logic [2:0]  cmd_code = 3'h0;
    logic [15:0] integ_cycles = 16'h0001;
    logic [7:0]  pixel_data = 8'h00, temp_adc = 8'h00, out_data_ff;
    logic [8:0]  e, exp_q[$];
    logic [1:0]  res = `RES_8BIT;
    int          num_errors = 0, total_checks = 0, n;
    localparam int CONV = 4, ZEB = 3;
    linear_array_frame_sequencer #(.CONV_CYCLES(CONV), .ZEB_CYCLES(ZEB))
        linear_array_frame_sequencer_inst (.ref_clk, .arst_n, .cmd_valid,
        .cmd_code, .integ_cycles, .resolution(res), .chip_select,
        .pixel_data, .temp_adc, .rd_req(1'h0), .out_valid_ff, .out_data_ff,
        .out_ready, .frame_available_flag_ff(fl), .initialised_ff(ini),
        .cmd_error_ff(err));
    host_rx_model host_rx_model_inst (.ref_clk, .arst_n,
        .frame_available_flag_ff(fl), .out_ready);
    initial forever #5 ref_clk = ~ref_clk;
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'h1) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic send(input logic [2:0] c);
        @(posedge ref_clk) #1;
        cmd_code = c;
        cmd_valid = 1'h1;
        @(posedge ref_clk) #1;
        cmd_valid = 1'h0;
    endtask
    task automatic frame(input logic [2:0] c, input logic d,
                         input logic [1:0] r);
        pixel_data = 8'($urandom);
        temp_adc = 8'($urandom);
        res = r;
        integ_cycles = 16'(1 + $urandom % 8);
        for (int i = 0; i < 16; i++) exp_q.push_back({d, i != 6 ||
            res != `RES_8BIT ? pixel_data :
            c == `CMD_ZEBRA_ALL_LOW ? `DARK_LEVEL : temp_adc});
        send(`CMD_WRITE_THRESHOLD);
        send(c);
        chk(fl === 1'h0, "flag not cleared");
        if (c != `CMD_START_INTEG) begin
            repeat (10) @(posedge ref_clk);
            #1 chk(fl === 1'h0, "zebra ran without cs");
            chip_select = 1'h1;
        end
        for (n = 0; fl !== 1'h1 && n < 200; n++) @(posedge ref_clk) #1;
        chk(n == (c == `CMD_START_INTEG ? integ_cycles + 1 : ZEB + 2) + CONV,
            "ready timing");
        for (n = 0; exp_q.size() > 0 && n < 500; n++) @(posedge ref_clk) #1;
        chk(exp_q.size() == 0, "stream incomplete");
        chip_select = 1'h0;
    endtask
    // sampled mid-cycle, where the handshake that the next edge takes is stable
    always @(negedge ref_clk) begin
        if (out_valid_ff === 1'h1 && out_ready === 1'h1) begin
            e = exp_q.size() ? exp_q.pop_front() : 9'h0ff;
            if (!e[8]) chk(out_data_ff === e[7:0], "byte mismatch");
        end
    end
    task automatic conclude;
        if (num_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        void'($urandom(27));
        repeat (2) @(posedge ref_clk);
        #1 arst_n = 1'h1;
        chk(ini === 1'h0 && err === 1'h0 && fl === 1'h0, "reset state");
        send(`CMD_START_INTEG);
        chk(err === 1'h1, "start before chip reset taken");
        send(`CMD_CHIP_RESET);
        chk(ini === 1'h1 && err === 1'h0, "chip reset");
        frame(`CMD_START_INTEG, 1'h1, `RES_8BIT);
        for (int k = 0; k < 8; k++)
            frame(k < 4 ? `CMD_START_INTEG : 3'(k), 1'h0,
                  k[0] ? 2'(1 + $urandom % 3) : `RES_8BIT);
        conclude();
    end
    // nine frames take well under 2000 cycles; allow ten times that
    initial begin
        #200000;
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire
